// File: bst_ctrl.sv
// Self-test, counter segmentation and boundary-scan controller
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.svh"
// How it works
// - Outside a run the block drives no data path; the test mux select stays off; loop selects follow their bits, remote only with the EB loop bit clear.
// - Setting the run bit in control register A starts the self-test.
// - First cycle initialises path, pattern source, signature and scan mode; then run.
// - Pattern source is a 16-bit shift register stepped every clock, 65535 patterns.
// - The test is complete when the pattern register reaches zero.
// - At completion the signature freezes and stays readable over the register port.
// - Completion of a run raises the interrupt output.
// - Interrupt clears only by writing run bit zero, never by reading events.
// - Writing the run bit to zero before completion aborts the test.
// - Pattern data goes into the transmit output latch through the test mux.
// - Transmit latch data loops into the framer input via local loopback.
// - Decoder output feeds the signature and loops into the transmit path.
// - Signature samples data before filter blocks; those add observation bits.
// - In test mode machine state bits form a chain feeding one signature bit.
// - Counter segmentation mode splits counters into independent 4-bit pieces.
// - Boundary chain shifts serially, captures in parallel, then shifts out.
// - Chain input is the first test pin, output the scan output pin.
// - Chain order runs symbol in, optic off, symbol out, transmit pair, parities, receive pair, bus.
// - Only the output half of the processor bus joins the chain.
// - All chain shifting and capture run on the block clock.
// - During a run the test mux takes the self-test source over the encoder.
// - During a run remote loopback is forced regardless of its control bit.
module bst_ctrl #(
    parameter int LFSR_W = `BST_LFSR_W,
    parameter int SEG_W  = `BST_SEG_W
) (
    // Clock, reset, enable
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    ce,
    // Register port
    input  wire logic [`BST_ADDR_W-1:0]  reg_addr,
    input  wire logic [`BST_DATA_W-1:0]  reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`BST_DATA_W-1:0]  reg_rdata,
    output logic                         selftest_irq,
    // Data path
    input  wire bst_pkg::bst_obs_t       obs,
    output logic      [9:0]              tx_test_pair,
    output logic                         test_mux_sel,
    output logic                         eb_loop_sel,
    output logic                         rem_loop_sel,
    output logic                         dp_init,
    // Test modes
    output logic                         sm_scan_mode,
    output logic                         cnt_seg_mode,
    output logic                         bscan_mode,
    // Boundary scan
    input  wire logic                    test0_in,
    input  wire logic                    bscan_shift,
    input  wire logic                    bscan_capture,
    input  wire bst_pkg::bst_pins_t      pins,
    output logic                         scan_out_pin,
    output logic      [48:0]             bscan_chain
);

    // The step functions are written for these sizes only
    if (LFSR_W != `BST_LFSR_W || SEG_W != `BST_SEG_W)
    begin : g_size_check
        $error("bst_ctrl: only a 16-bit pattern source with 4-bit segments is supported");
    end

    bst_pkg::bst_regs_t r_q;
    bst_pkg::bst_regs_t r_d;

    // De Bruijn step: the all-zero state is part of the cycle, so a run ends on zero
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        logic fb;
        fb = s[15] ^ s[14] ^ s[12] ^ s[3] ^ (s[14:0] == 15'h0000);
        return {s[14:0], fb};
    endfunction

    function automatic logic [15:0] sig_step(input logic [15:0] s, input logic [13:0] din);
        logic fb;
        fb = s[15] ^ s[14] ^ s[12] ^ s[3];
        return {s[14:0], fb} ^ {2'h0, din};
    endfunction

    // Segmented increment: carries stop at every 4-bit boundary when seg is set
    function automatic logic [15:0] cnt_inc(input logic [15:0] c, input logic seg);
        logic [15:0] res;
        logic        cy;
        res = c;
        cy  = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            if (seg && (i % 4 == 0))
                cy = 1'b1;
            res[i] = c[i] ^ cy;
            cy     = c[i] & cy;
        end
        return res;
    endfunction

    // Chain position 0 is nearest the serial input
    function automatic logic [48:0] chain_load(input bst_pkg::bst_pins_t p);
        logic [48:0] v;
        v = '0;
        for (int i = 0; i < 5; i++)
            v[i] = p.symbol_rx_in[i];
        v[5] = p.optic_off_out;
        for (int i = 0; i < 5; i++)
            v[6 + i] = p.symbol_tx_out[4 - i];
        for (int i = 0; i < 10; i++)
            v[11 + i] = p.pair_tx_in[i];
        v[21] = p.tx_parity_in;
        v[22] = p.rx_parity_out;
        for (int i = 0; i < 10; i++)
            v[23 + i] = p.pair_rx_out[9 - i];
        for (int i = 0; i < 16; i++)
            v[33 + i] = p.processor_data_bus[15 - i];
        return v;
    endfunction

    logic        wr_ctrl;
    logic        run_wr0;
    logic        running;
    logic [13:0] obs_bits;

    assign wr_ctrl  = reg_wr && (reg_addr == `BST_OFS_CTRL_A);
    assign run_wr0  = wr_ctrl && !reg_wdata[`BST_CTRL_RUN];
    assign running  = (r_q.st == bst_pkg::BST_RUN);
    assign obs_bits = {obs.dec_pair, obs.rf_obs, obs.dsg_obs, obs.enc_obs, obs.sm_scan_out};

    always_comb
    begin
        r_d         = r_q;
        r_d.dp_init = 1'b0;

        if (wr_ctrl)
            r_d.ctrl = reg_wdata[`BST_CTRL_W-1:0];

        unique case (r_q.st)
            bst_pkg::BST_IDLE:
            begin
                if (wr_ctrl && reg_wdata[`BST_CTRL_RUN])
                begin
                    r_d.st      = bst_pkg::BST_INIT;
                    r_d.lfsr    = `BST_LFSR_SEED;
                    r_d.sig     = `BST_SIG_RST;
                    r_d.cyc     = 16'h0000;
                    r_d.dp_init = 1'b1;
                end
            end
            bst_pkg::BST_INIT:
            begin
                r_d.st = bst_pkg::BST_RUN;
            end
            bst_pkg::BST_RUN:
            begin
                if (r_q.lfsr == 16'h0000)
                begin
                    r_d.st   = bst_pkg::BST_DONE;
                    r_d.done = 1'b1;
                end
                else
                begin
                    r_d.lfsr = lfsr_step(r_q.lfsr);
                    r_d.sig  = sig_step(r_q.sig, obs_bits);
                    r_d.cyc  = cnt_inc(r_q.cyc, r_q.ctrl[`BST_CTRL_CNT_SEG]);
                end
            end
            bst_pkg::BST_DONE:
            begin
                // Signature held: nothing advances here
            end
        endcase

        // Zero on the run bit aborts or clears; a same-cycle completion still latches
        if (run_wr0)
        begin
            r_d.st = bst_pkg::BST_IDLE;
            if (!(running && r_q.lfsr == 16'h0000))
                r_d.done = 1'b0;
        end

        r_d.test_sel     = (r_d.st == bst_pkg::BST_RUN);
        r_d.txd          = (r_d.st == bst_pkg::BST_RUN) ? r_d.lfsr[9:0] : 10'h000;
        r_d.eb_sel       = r_d.test_sel || r_d.ctrl[`BST_CTRL_EB_LOOP];
        r_d.rem_sel      = r_d.test_sel
                           || (r_d.ctrl[`BST_CTRL_REM_LOOP] && !r_d.ctrl[`BST_CTRL_EB_LOOP]);
        r_d.sm_scan_mode = (r_d.st == bst_pkg::BST_INIT) || (r_d.st == bst_pkg::BST_RUN);
        r_d.seg_mode     = r_d.ctrl[`BST_CTRL_CNT_SEG];
        r_d.bscan_mode   = r_d.ctrl[`BST_CTRL_BSCAN];

        // Boundary chain, clocked by the block clock
        if (r_q.bscan_mode)
        begin
            if (bscan_capture)
                r_d.chain = chain_load(pins);
            else if (bscan_shift)
                r_d.chain = {r_q.chain[47:0], test0_in};
        end

        r_d.rdata = 16'h0000;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `BST_OFS_CTRL_A:  r_d.rdata = {11'h000, r_q.ctrl};
                `BST_OFS_INT_EVT: r_d.rdata = {15'h0000, r_q.done};
                `BST_OFS_SIG:     r_d.rdata = r_q.sig;
                `BST_OFS_LFSR:    r_d.rdata = r_q.lfsr;
                `BST_OFS_STATUS:  r_d.rdata = {14'h0000, r_q.st};
                `BST_OFS_CYCLES:  r_d.rdata = r_q.cyc;
                default:          r_d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r_q       <= '0;
            r_q.st    <= bst_pkg::BST_IDLE;
            r_q.ctrl  <= `BST_CTRL_RST;
            r_q.lfsr  <= `BST_LFSR_SEED;
            r_q.sig   <= `BST_SIG_RST;
        end
        else if (ce)
        begin
            r_q <= r_d;
        end
    end

    assign reg_rdata    = r_q.rdata;
    assign selftest_irq = r_q.done;
    assign tx_test_pair = r_q.txd;
    assign test_mux_sel = r_q.test_sel;
    assign eb_loop_sel  = r_q.eb_sel;
    assign rem_loop_sel = r_q.rem_sel;
    assign dp_init      = r_q.dp_init;
    assign sm_scan_mode = r_q.sm_scan_mode;
    assign cnt_seg_mode = r_q.seg_mode;
    assign bscan_mode   = r_q.bscan_mode;
    assign scan_out_pin = r_q.chain[48];
    assign bscan_chain  = r_q.chain;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_passive;
        (r_q.st != bst_pkg::BST_RUN) |-> (tx_test_pair == 10'h000) && !test_mux_sel;
    endproperty
    a_passive: assert property (p_passive) else $error("self-test drives data path while idle");

    property p_start;
        ce && r_q.st == bst_pkg::BST_IDLE && reg_wr && reg_addr == `BST_OFS_CTRL_A && reg_wdata[0]
            |=> r_q.st == bst_pkg::BST_INIT && dp_init && r_q.lfsr == `BST_LFSR_SEED;
    endproperty
    a_start: assert property (p_start) else $error("run bit did not start initialisation");

    property p_init_then_run;
        ce && r_q.st == bst_pkg::BST_INIT && !run_wr0 |=> r_q.st == bst_pkg::BST_RUN && sm_scan_mode;
    endproperty
    a_init_then_run: assert property (p_init_then_run) else $error("init not followed by run");

    property p_lfsr_step;
        ce && running && r_q.lfsr != 16'h0000 && !run_wr0 |=> r_q.lfsr == lfsr_step($past(r_q.lfsr));
    endproperty
    a_lfsr_step: assert property (p_lfsr_step) else $error("pattern register did not step");

    property p_end_on_zero;
        ce && running && r_q.lfsr == 16'h0000 |=> selftest_irq;
    endproperty
    a_end_on_zero: assert property (p_end_on_zero) else $error("zero pattern did not complete test");

    property p_frozen;
        r_q.st == bst_pkg::BST_DONE ##1 r_q.st == bst_pkg::BST_DONE |-> $stable(r_q.sig);
    endproperty
    a_frozen: assert property (p_frozen) else $error("signature changed after completion");

    property p_read_no_clear;
        ce && selftest_irq && reg_rd && !reg_wr |=> selftest_irq;
    endproperty
    a_read_no_clear: assert property (p_read_no_clear) else $error("read cleared interrupt");

    property p_abort;
        ce && run_wr0 && !(running && r_q.lfsr == 16'h0000)
            |=> r_q.st == bst_pkg::BST_IDLE && !selftest_irq;
    endproperty
    a_abort: assert property (p_abort) else $error("run bit zero did not abort");

    property p_loops;
        test_mux_sel |-> eb_loop_sel && rem_loop_sel && tx_test_pair == r_q.lfsr[9:0];
    endproperty
    a_loops: assert property (p_loops) else $error("loopbacks or injection wrong during run");

    property p_shift;
        ce && bscan_mode && bscan_shift && !bscan_capture |=> bscan_chain[0] == $past(test0_in)
            && scan_out_pin == $past(bscan_chain[47]);
    endproperty
    a_shift: assert property (p_shift) else $error("boundary chain shift wrong");

    property p_capture;
        ce && bscan_mode && bscan_capture |=> bscan_chain[0] == $past(pins.symbol_rx_in[0])
            && bscan_chain[48] == $past(pins.processor_data_bus[0]);
    endproperty
    a_capture: assert property (p_capture) else $error("boundary chain capture order wrong");

    // Counter and signature-step checks apply only to cycles that step the pattern
    property p_cnt_flat;
        ce && running && r_q.lfsr != 16'h0000 && !r_q.ctrl[`BST_CTRL_CNT_SEG]
            |=> r_q.cyc == $past(r_q.cyc) + 16'h0001;
    endproperty
    a_cnt_flat: assert property (p_cnt_flat) else $error("run counter did not step by one");

    property p_cnt_seg;
        ce && running && r_q.lfsr != 16'h0000 && r_q.ctrl[`BST_CTRL_CNT_SEG]
            |=> r_q.cyc[3:0] == $past(r_q.cyc[3:0]) + 4'h1
                && r_q.cyc[15:12] == $past(r_q.cyc[15:12]) + 4'h1;
    endproperty
    a_cnt_seg: assert property (p_cnt_seg) else $error("counter nibbles did not step alone");

    property p_sig_step;
        ce && running && r_q.lfsr != 16'h0000
            |=> r_q.sig == sig_step($past(r_q.sig), $past(obs_bits));
    endproperty
    a_sig_step: assert property (p_sig_step) else $error("signature did not fold observed bits");

    property p_sig_read;
        ce && reg_rd && reg_addr == `BST_OFS_SIG |=> reg_rdata == $past(r_q.sig);
    endproperty
    a_sig_read: assert property (p_sig_read) else $error("signature read returned wrong value");

    property p_irq_hold;
        ce && selftest_irq && !run_wr0 |=> selftest_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without run bit clear");

    property p_init_pulse;
        ce && dp_init |=> !dp_init;
    endproperty
    a_init_pulse: assert property (p_init_pulse) else $error("init pulse longer than one cycle");

    property p_start_ignored;
        ce && r_q.st != bst_pkg::BST_IDLE && wr_ctrl && reg_wdata[`BST_CTRL_RUN]
            |=> r_q.st != bst_pkg::BST_IDLE;
    endproperty
    a_start_ignored: assert property (p_start_ignored) else $error("run bit rewrite disturbed a test");

    property p_chain_hold;
        ce && !bscan_mode |=> $stable(bscan_chain);
    endproperty
    a_chain_hold: assert property (p_chain_hold) else $error("boundary chain moved outside scan mode");

    property p_scan_mode;
        r_q.st == bst_pkg::BST_IDLE || r_q.st == bst_pkg::BST_DONE |-> !sm_scan_mode;
    endproperty
    a_scan_mode: assert property (p_scan_mode) else $error("scan mode left on outside a test");

    // Stall check covers every register, outputs included
    property p_freeze;
        !ce |=> $stable(r_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while enable low");

    c_start: cover property (r_q.st == bst_pkg::BST_INIT ##1 r_q.st == bst_pkg::BST_RUN);
    c_seg:   cover property (running && cnt_seg_mode);
    c_done:  cover property (running ##1 r_q.st == bst_pkg::BST_DONE);
    c_abort: cover property (running && run_wr0);
    c_scan:  cover property (bscan_mode && bscan_capture ##1 bscan_shift);

endmodule // bst_ctrl
`default_nettype wire

// File: bst_ctrl_tb.sv
// Self-checking bench for the self-test and scan controller
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.svh"
module bst_ctrl_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic selftest_irq, test_mux_sel, eb_loop_sel, rem_loop_sel, dp_init;
    logic sm_scan_mode, cnt_seg_mode, bscan_mode, scan_out_pin;
    logic [9:0] tx_test_pair;
    logic [48:0] bscan_chain, m;
    logic test0_in = 1'b0;
    logic ce = 1'b1;
    logic bscan_shift = 1'b0;
    logic bscan_capture = 1'b0;
    bst_pkg::bst_obs_t obs;
    bst_pkg::bst_pins_t pins = '0;
    integer seed = 940;
    int err_total = 0;
    int checks_done = 0;
    int cyc_cnt = 0;
    int n;
    logic [15:0] v, s1, s2;
    logic b;

    always #25 clk = ~clk;

    bst_ctrl dut_u (.clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .selftest_irq(selftest_irq), .obs(obs),
        .tx_test_pair(tx_test_pair), .test_mux_sel(test_mux_sel), .eb_loop_sel(eb_loop_sel),
        .rem_loop_sel(rem_loop_sel), .dp_init(dp_init), .sm_scan_mode(sm_scan_mode),
        .cnt_seg_mode(cnt_seg_mode), .bscan_mode(bscan_mode), .test0_in(test0_in),
        .bscan_shift(bscan_shift), .bscan_capture(bscan_capture), .pins(pins),
        .scan_out_pin(scan_out_pin), .bscan_chain(bscan_chain));

    bst_path_model path_u (.clk(clk), .srst(srst), .tx_test_pair(tx_test_pair), .eb_loop_sel(eb_loop_sel),
        .rem_loop_sel(rem_loop_sel), .sm_scan_mode(sm_scan_mode), .obs(obs));

    task automatic test_done();
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Pin-to-position map of the boundary chain
    function automatic logic [48:0] exp_chain(input bst_pkg::bst_pins_t p);
        logic [48:0] c;
        for (int k = 0; k < 5; k++)
        begin
            c[k] = p.symbol_rx_in[k];
            c[6+k] = p.symbol_tx_out[4-k];
        end
        c[5] = p.optic_off_out;
        for (int k = 0; k < 10; k++)
        begin
            c[11+k] = p.pair_tx_in[k];
            c[23+k] = p.pair_rx_out[9-k];
        end
        c[21] = p.tx_parity_in;
        c[22] = p.rx_parity_out;
        for (int k = 0; k < 16; k++)
            c[33+k] = p.processor_data_bus[15-k];
        return c;
    endfunction

    // Start a run and check the init pulse and the forced selects
    task automatic start_run(input logic [15:0] d);
        wr(`BST_OFS_CTRL_A, d);
        chk({dp_init, sm_scan_mode, test_mux_sel}, 3'b110);
        @(posedge clk);
        #1;
        chk({dp_init, sm_scan_mode, test_mux_sel, eb_loop_sel, rem_loop_sel}, 5'h0F);
    endtask

    always @(posedge clk)
    begin
        cyc_cnt++;
        // Full run is about 65.5k cycles, leave margin
        if (cyc_cnt == 80000)
        begin
            err_total++;
            test_done();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(`BST_OFS_LFSR, v);
        chk(v, `BST_LFSR_SEED);
        rd(`BST_OFS_SIG, v);
        chk(v, `BST_SIG_RST);
        rd(4'hF, v);
        chk(v, 16'h0000);
        wr(`BST_OFS_SIG, 16'hFFFF);
        rd(`BST_OFS_SIG, v);
        chk(v, `BST_SIG_RST);
        // Mode bits with run bit clear: self-test stays passive
        for (int i = 0; i < 8; i++)
        begin
            v = 16'($random(seed));
            v[0] = 1'b0;
            if (i < 2) v[2:1] = 2'(i + 2);
            wr(`BST_OFS_CTRL_A, v);
            @(posedge clk);
            #1;
            chk({test_mux_sel, tx_test_pair, dp_init, selftest_irq}, '0);
            chk({eb_loop_sel, rem_loop_sel}, {v[1], v[2] & ~v[1]});
            chk({bscan_mode, cnt_seg_mode}, v[4:3]);
            rd(`BST_OFS_CTRL_A, s1);
            chk(s1, {11'h000, v[4:0]});
        end
        // Boundary scan: capture pins, then shift the chain out
        wr(`BST_OFS_CTRL_A, 16'h0010);
        @(posedge clk);
        pins <= bst_pkg::bst_pins_t'(49'({$random(seed), $random(seed)}));
        bscan_capture <= 1'b1;
        @(posedge clk);
        bscan_capture <= 1'b0;
        bscan_shift <= 1'b1;
        b = 1'($random(seed));
        test0_in <= b;
        m = exp_chain(pins);
        #1;
        chk(bscan_chain, m);
        repeat (49)
        begin
            @(posedge clk);
            m = {m[47:0], b};
            b = 1'($random(seed));
            test0_in <= b;
            #1;
            chk(bscan_chain, m);
            chk(scan_out_pin, m[48]);
        end
        bscan_shift <= 1'b0;
        wr(`BST_OFS_CTRL_A, 16'h0000);
        // Abort in mid-run, segmented counter on, with an enable stall
        start_run(16'h0009);
        repeat (100) @(posedge clk);
        ce <= 1'b0;
        #1;
        s1 = 16'(tx_test_pair);
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        #1;
        chk(tx_test_pair, s1[9:0]);
        rd(`BST_OFS_STATUS, v);
        chk(v, 16'h0002);
        wr(`BST_OFS_CTRL_A, 16'h0000);
        @(posedge clk);
        #1;
        chk({test_mux_sel, selftest_irq, sm_scan_mode, tx_test_pair}, '0);
        rd(`BST_OFS_STATUS, v);
        chk(v, 16'h0000);
        // 104 enabled steps before the abort: each nibble alone reaches 8
        rd(`BST_OFS_CYCLES, v);
        chk(v, 16'h8888);
        // Full run to completion
        start_run(16'h0001);
        n = 1;
        while (selftest_irq !== 1'b1 && n < 70000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, `BST_PATTERNS + 2);
        rd(`BST_OFS_LFSR, v);
        chk(v, 16'h0000);
        rd(`BST_OFS_CYCLES, v);
        chk(v, 16'hFFFF);
        rd(`BST_OFS_SIG, s1);
        chk(s1 != 16'h0000, 1'b1);
        repeat (20) @(posedge clk);
        rd(`BST_OFS_SIG, s2);
        chk(s2, s1);
        rd(`BST_OFS_INT_EVT, v);
        chk(v[`BST_INT_DONE], 1'b1);
        rd(`BST_OFS_INT_EVT, v);
        chk(selftest_irq, 1'b1);
        chk(test_mux_sel, 1'b0);
        rd(`BST_OFS_STATUS, v);
        chk(v, 16'h0003);
        wr(`BST_OFS_CTRL_A, 16'h0000);
        @(posedge clk);
        #1;
        chk(selftest_irq, 1'b0);
        test_done();
    end
endmodule // bst_ctrl_tb
`default_nettype wire

// File: bst_map.svh
// Register offsets, field positions, reset values and counts of the self-test controller
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

`define BST_ADDR_W        4
`define BST_DATA_W        16

`define BST_OFS_CTRL_A    4'h0
`define BST_OFS_INT_EVT   4'h1
`define BST_OFS_SIG       4'h2
`define BST_OFS_LFSR      4'h3
`define BST_OFS_STATUS    4'h4
`define BST_OFS_CYCLES    4'h5

`define BST_CTRL_RUN      0
`define BST_CTRL_EB_LOOP  1
`define BST_CTRL_REM_LOOP 2
`define BST_CTRL_CNT_SEG  3
`define BST_CTRL_BSCAN    4
`define BST_CTRL_W        5
`define BST_CTRL_RST      5'h00

`define BST_INT_DONE      0

`define BST_LFSR_W        16
`define BST_LFSR_SEED     16'h0001
`define BST_SIG_W         16
`define BST_SIG_RST       16'h0000
`define BST_PAIR_W        10
`define BST_SEG_W         4

`define BST_CHAIN_LEN     49
`define BST_BYTE_CLK_NS   80
`define BST_PATTERNS      65535

`endif

// File: bst_path_model.sv
// Data path stand-in that loops the test pair back as observation bits
`timescale 1ns/1ps
`default_nettype none
module bst_path_model (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           srst,
    // Selects and pattern from the controller
    input  wire logic [9:0]     tx_test_pair,
    input  wire logic           eb_loop_sel,
    input  wire logic           rem_loop_sel,
    input  wire logic           sm_scan_mode,
    // Observation bits back to the signature
    output var bst_pkg::bst_obs_t obs
);
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            obs <= '0;
        end
        else
        begin
            // Open loop: decoder output toggles so stale data never looks valid
            obs.dec_pair    <= eb_loop_sel ? tx_test_pair : ~obs.dec_pair;
            obs.rf_obs      <= rem_loop_sel ^ (^tx_test_pair);
            obs.dsg_obs     <= tx_test_pair[0];
            obs.enc_obs     <= tx_test_pair[9];
            obs.sm_scan_out <= sm_scan_mode & ~obs.sm_scan_out;
        end
    end
endmodule // bst_path_model
`default_nettype wire

// File: bst_pkg.sv
// Types shared by the self-test controller
`default_nettype none
package bst_pkg;

    typedef enum logic [1:0] {
        BST_IDLE,
        BST_INIT,
        BST_RUN,
        BST_DONE
    } bst_state_t;

    // Observation signals fed to the signature register
    typedef struct packed {
        logic [9:0] dec_pair;
        logic       rf_obs;
        logic       dsg_obs;
        logic       enc_obs;
        logic       sm_scan_out;
    } bst_obs_t;

    // Pin values captured into the boundary chain
    typedef struct packed {
        logic [4:0]  symbol_rx_in;
        logic        optic_off_out;
        logic [4:0]  symbol_tx_out;
        logic [9:0]  pair_tx_in;
        logic        tx_parity_in;
        logic        rx_parity_out;
        logic [9:0]  pair_rx_out;
        logic [15:0] processor_data_bus;
    } bst_pins_t;

    typedef struct packed {
        bst_state_t  st;
        logic [4:0]  ctrl;
        logic        done;
        logic [15:0] lfsr;
        logic [15:0] sig;
        logic [15:0] cyc;
        logic [9:0]  txd;
        logic        test_sel;
        logic        eb_sel;
        logic        rem_sel;
        logic        dp_init;
        logic        sm_scan_mode;
        logic        seg_mode;
        logic        bscan_mode;
        logic [15:0] rdata;
        logic [48:0] chain;
    } bst_regs_t;

endpackage
`default_nettype wire
